// ### design/mcg_pkg.sv
// mcg_pkg: constants, register map and types of the coded serial transmitter
// ****************************************************************************
// ****************************************************************************
package mcg_pkg;
	// ************************************************************************
	// register map (byte addresses)
	// ************************************************************************
	localparam logic [15:0] MCG_ADDR_CTL0   = 16'hff48;
	localparam logic [15:0] MCG_ADDR_CTL1   = 16'hff49;
	localparam logic [15:0] MCG_ADDR_RATE   = 16'hff4e;
	localparam logic [15:0] MCG_ADDR_TXBUF  = 16'hff4a;
	localparam logic [15:0] MCG_ADDR_BITCNT = 16'hff4b;
	localparam logic [15:0] MCG_ADDR_STATE  = 16'hff4c;

	// ************************************************************************
	// reset values and fields
	// ************************************************************************
	localparam logic [7:0] MCG_RST_CTL0   = 8'h00;
	localparam logic [7:0] MCG_RST_CTL1   = 8'h00;
	localparam logic [4:0] MCG_RST_RATE   = 5'h1f;
	localparam logic [7:0] MCG_RST_TXBUF  = 8'h00;
	localparam logic [2:0] MCG_RST_BITCNT = 3'h7;
	localparam logic [7:0] MCG_RST_STATE  = 8'h00;
	localparam int MCG_CTL0_PWR   = 7;
	localparam int MCG_CTL0_MODE  = 4;
	localparam int MCG_CTL0_MSB   = 3;
	localparam int MCG_CTL0_INV   = 2;
	localparam int MCG_CTL0_ENA   = 0;
	localparam int MCG_ST_BUSY    = 0;
	localparam int MCG_ST_PEND    = 1;
	localparam logic [4:0] MCG_DIV_MIN  = 5'h04;
	localparam logic [4:0] MCG_DIV_ONE  = 5'h01;
	localparam logic [7:0] MCG_PRE_ONE  = 8'h01;
	localparam logic [2:0] MCG_CKS_MAX  = 3'h7;
	localparam logic [2:0] MCG_BIT_ONE  = 3'h1;
	localparam logic [2:0] MCG_BIT_LAST = 3'h7;

	// ************************************************************************
	// types
	// ************************************************************************
	typedef enum logic {MCG_MODE_MANCH, MCG_MODE_SEQ} mcg_mode_t;

	typedef struct packed {
		logic [7:0] data;
		logic [2:0] lastBit;
	} mcg_word_t;

	typedef struct packed {
		logic        wrEn;
		logic        rdEn;
		logic [15:0] addr;
		logic [7:0]  wrData;
	} mcg_bus_t;
endpackage

// ### design/mcg_transmitter.sv
// mcg_transmitter: coded serial transmitter with registers and two-entry buffer
`timescale 1ns/1ps
`default_nettype none
module mcg_transmitter
(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            srst,
	// register access
	input  wire mcg_pkg::mcg_bus_t bus,
	output var  logic [7:0]      rdData,
	// serial line
	output var  logic            codedSerialOut
);
	import mcg_pkg::*;

	// ************************************************************************
	// registers
	// ************************************************************************
	logic [7:0] mainControlReg_q;
	logic [2:0] baseClockSel_q;
	logic [4:0] rateDividerSel_q;
	logic [7:0] txDataBuffer_q;
	logic [2:0] txBitCountReg_q;
	logic       unitPowerOn;
	logic       enabled;
	logic       busy_q;
	logic [7:0] unitStateReg;

	assign unitPowerOn = mainControlReg_q[MCG_CTL0_PWR];
	assign enabled     = unitPowerOn & mainControlReg_q[MCG_CTL0_ENA];

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			mainControlReg_q <= MCG_RST_CTL0;
			baseClockSel_q   <= MCG_RST_CTL1[2:0];
			rateDividerSel_q <= MCG_RST_RATE;
			txDataBuffer_q   <= MCG_RST_TXBUF;
			txBitCountReg_q  <= MCG_RST_BITCNT;
		end
		else if (bus.wrEn)
		begin
			case (bus.addr)
				MCG_ADDR_CTL0:   mainControlReg_q <= bus.wrData;
				MCG_ADDR_CTL1:   baseClockSel_q   <= bus.wrData[2:0];
				MCG_ADDR_RATE:   rateDividerSel_q <= bus.wrData[4:0];
				MCG_ADDR_TXBUF:  txDataBuffer_q   <= bus.wrData;
				MCG_ADDR_BITCNT: txBitCountReg_q  <= bus.wrData[2:0];
				default:         ;
			endcase
		end
	end

	// ************************************************************************
	// two-entry buffer between register writes and shifter
	// ************************************************************************
	mcg_word_t bufMem_q [2];
	logic      wrPtr_q;
	logic      rdPtr_q;
	logic [1:0] count_q;
	logic      inValid;
	logic      inReady;
	logic      outValid;
	logic      outReady;

	assign inValid  = bus.wrEn && bus.addr == MCG_ADDR_TXBUF && enabled;
	assign inReady  = count_q != 2'h2;
	assign outValid = count_q != 2'h0;

	always_ff @(posedge clk)
	begin
		if (srst || !enabled)
		begin
			wrPtr_q <= 1'b0;
			rdPtr_q <= 1'b0;
			count_q <= 2'h0;
		end
		else
		begin
			if (inValid && inReady)
			begin
				bufMem_q[wrPtr_q] <= '{data: bus.wrData, lastBit: txBitCountReg_q};
				wrPtr_q <= ~wrPtr_q;
			end
			if (outValid && outReady)
				rdPtr_q <= ~rdPtr_q;
			count_q <= count_q + 2'((inValid && inReady) ? 1 : 0)
				- 2'((outValid && outReady) ? 1 : 0);
		end
	end

	// ************************************************************************
	// base clock prescaler and 5-bit counter
	// ************************************************************************
	logic [9:0] preCnt_q;
	logic       baseTick;
	logic [4:0] divK;
	logic [4:0] divCnt_q;
	logic       divTick;
	logic       halfTick;
	logic       phase_q;

	// base clock select picks clk / 2^sel
	assign baseTick = (preCnt_q & ((10'h1 << baseClockSel_q) - 10'h1)) == 10'h0;
	assign divK = (rateDividerSel_q < MCG_DIV_MIN) ? MCG_DIV_MIN : rateDividerSel_q;
	assign divTick = baseTick && divCnt_q == divK - MCG_DIV_ONE;

	always_ff @(posedge clk)
	begin
		if (srst || !busy_q)
		begin
			preCnt_q <= 10'h0;
			divCnt_q <= 5'h0;
			phase_q  <= 1'b0;
		end
		else
		begin
			preCnt_q <= preCnt_q + 10'h1;
			if (baseTick)
				divCnt_q <= divTick ? 5'h0 : divCnt_q + MCG_DIV_ONE;
			if (divTick)
				phase_q <= ~phase_q;
		end
	end

	// in both modes each counter tick is a half bit, so a full bit takes two
	assign halfTick = divTick;

	// ************************************************************************
	// shifter
	// ************************************************************************
	mcg_word_t cur_q;
	logic [2:0] bitIdx_q;
	logic       curBit;
	logic       lineLevel;
	logic       bitDone;
	logic       mode;
	logic       inv;

	assign mode     = mainControlReg_q[MCG_CTL0_MODE];
	assign inv      = mainControlReg_q[MCG_CTL0_INV];
	assign curBit   = mainControlReg_q[MCG_CTL0_MSB]
		? cur_q.data[3'(MCG_BIT_LAST - bitIdx_q)] : cur_q.data[bitIdx_q];
	assign bitDone  = halfTick && phase_q;
	assign outReady = !busy_q;

	always_ff @(posedge clk)
	begin
		if (srst || !enabled)
		begin
			busy_q   <= 1'b0;
			bitIdx_q <= 3'h0;
			cur_q    <= '0;
		end
		else if (!busy_q && outValid)
		begin
			cur_q    <= bufMem_q[rdPtr_q];
			bitIdx_q <= 3'h0;
			busy_q   <= 1'b1;
		end
		else if (busy_q && bitDone)
		begin
			if (bitIdx_q == cur_q.lastBit)
				busy_q <= 1'b0;
			else
				bitIdx_q <= bitIdx_q + MCG_BIT_ONE;
		end
	end

	always_comb
	begin
		if (mcg_mode_t'(mode) == MCG_MODE_MANCH)
			lineLevel = (curBit ^ phase_q) ^ inv;
		else
			lineLevel = curBit ^ inv;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			codedSerialOut <= 1'b0;
		else if (!busy_q)
			codedSerialOut <= inv;
		else
			codedSerialOut <= lineLevel;
	end

	// ************************************************************************
	// status and read path
	// ************************************************************************
	assign unitStateReg = unitPowerOn
		? {6'h0, outValid, busy_q} : MCG_RST_STATE;

	always_ff @(posedge clk)
	begin
		if (srst)
			rdData <= 8'h00;
		else if (bus.rdEn)
		begin
			case (bus.addr)
				MCG_ADDR_CTL0:   rdData <= mainControlReg_q;
				MCG_ADDR_CTL1:   rdData <= {5'h0, baseClockSel_q};
				MCG_ADDR_RATE:   rdData <= {3'h0, rateDividerSel_q};
				MCG_ADDR_TXBUF:  rdData <= txDataBuffer_q;
				MCG_ADDR_BITCNT: rdData <= {5'h0, txBitCountReg_q};
				MCG_ADDR_STATE:  rdData <= unitStateReg;
				default:         rdData <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### verif/mcg_line_rx.sv
// mcg_line_rx: receiver that samples half-bits off the serial line
`timescale 1ns/1ps
`default_nettype none
module mcg_line_rx
(
	// clock
	input  wire logic       clk,
	// line and start mark
	input  wire logic       line,
	input  wire logic       arm,
	// half-bits, first in top bit
	output var  logic [7:0] halves,
	output var  logic       done
);
	int cnt_q = 0;
	int got_q = 8;
	// sample in the middle of each 4-cycle half-bit
	always_ff @(posedge clk)
	begin
		if (arm)
		begin
			cnt_q <= 0;
			got_q <= 0;
		end
		else
		begin
			cnt_q <= cnt_q + 1;
			if (got_q < 8 && cnt_q >= 3 && (cnt_q - 3) % 4 == 0)
			begin
				halves <= {halves[6:0], line};
				got_q <= got_q + 1;
			end
		end
	end
	assign done = (got_q == 8);
endmodule
`default_nettype wire

// ### verif/mcg_chk.sv
// mcg_chk: port assertions of the coded serial transmitter
`timescale 1ns/1ps
`default_nettype none
module mcg_chk
(
	// clock and reset
	input wire logic             clk,
	input wire logic             srst,
	// watched ports
	input wire mcg_pkg::mcg_bus_t bus,
	input wire logic [7:0]       rdData,
	input wire logic             codedSerialOut
);
	import mcg_pkg::*;
	logic [4:0] rate_q;
	logic       pwr_q;
	logic       inv_q;
	logic       rdRate;
	logic       rdState;
	assign rdRate = bus.rdEn && bus.addr == MCG_ADDR_RATE;
	assign rdState = bus.rdEn && bus.addr == MCG_ADDR_STATE;
	always_ff @(posedge clk)
	begin
		if (srst)
			rate_q <= MCG_RST_RATE;
		else if (bus.wrEn && bus.addr == MCG_ADDR_RATE)
			rate_q <= bus.wrData[4:0];
	end
	always_ff @(posedge clk)
	begin
		if (srst)
			{pwr_q, inv_q} <= 2'h0;
		else if (bus.wrEn && bus.addr == MCG_ADDR_CTL0)
			{pwr_q, inv_q} <= {bus.wrData[MCG_CTL0_PWR], bus.wrData[MCG_CTL0_INV]};
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_rate_read: assert property (rdRate |=> rdData == {3'h0, rate_q})
		else $error("rate readback wrong");
	a_status_off: assert property (rdState && !pwr_q |=> rdData == 8'h00)
		else $error("status not clear while off");
	a_status_high: assert property (rdState |=> rdData[7:2] == 6'h00)
		else $error("status upper bits set");
	a_rd_hold: assert property (!bus.rdEn |=> $stable(rdData))
		else $error("read data moved");
	a_stop_idle: assert property (!pwr_q [*3] |-> codedSerialOut == inv_q)
		else $error("line not idle while off");
	a_half_min: assert property (pwr_q && $changed(codedSerialOut) |=>
		$stable(codedSerialOut) [*3])
		else $error("half-bit too short");
	a_reset_line: assert property (disable iff (1'b0) srst |=> !codedSerialOut)
		else $error("line not low in reset");
	a_reset_rd: assert property (disable iff (1'b0) srst |=> rdData == 8'h00)
		else $error("read data not clear in reset");
	c_rate_rd: cover property (rdRate);
	c_line_edge: cover property (pwr_q && $changed(codedSerialOut));
	c_state_on: cover property (rdState && pwr_q);
endmodule
bind mcg_transmitter mcg_chk u_mcg_chk (.clk(clk), .srst(srst), .bus(bus),
	.rdData(rdData), .codedSerialOut(codedSerialOut));
`default_nettype wire

// ### verif/tb.sv
// tb: register and line tests of the coded serial transmitter
`timescale 1ns/1ps
`default_nettype none
module tb;
	import mcg_pkg::*;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	mcg_bus_t   bus = '0;
	logic       arm = 1'b0;
	logic [7:0] rdData;
	logic       codedSerialOut;
	logic [7:0] halves;
	logic       done;
	int         mismatches = 0;
	int         tests_run = 0;
	always #12.5 clk = ~clk;
	mcg_transmitter u_mcg_transmitter (.clk(clk), .srst(srst), .bus(bus),
		.rdData(rdData), .codedSerialOut(codedSerialOut));
	mcg_line_rx u_mcg_line_rx (.clk(clk), .line(codedSerialOut), .arm(arm),
		.halves(halves), .done(done));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic s = 1'b0);
		@(posedge clk);
		bus <= {1'b1, 1'b0, a, d};
		arm <= s;
		@(posedge clk);
		bus <= '0;
		arm <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
		@(posedge clk);
		bus <= {1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		bus <= '0;
		#1 chk(n, e, rdData);
	endtask
	// line pattern: first half is bit^inv, second its inverse or a repeat
	task automatic xfer(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] e;
		logic       b;
		e = '0;
		for (int i = 0; i < 4; i++)
		begin
			b = c[MCG_CTL0_MSB] ? d[7 - i] : d[i];
			e = {e[5:0], b ^ c[MCG_CTL0_INV], (c[MCG_CTL0_MODE] ? b : ~b) ^ c[MCG_CTL0_INV]};
		end
		wr(MCG_ADDR_CTL0, c);
		repeat (8) @(posedge clk);
		wr(MCG_ADDR_TXBUF, d, 1'b1);
		repeat (2) @(posedge clk);
		rd(MCG_ADDR_STATE, 8'h01, "busy");
		for (int i = 0; i < 200 && done !== 1'b1; i++)
			@(posedge clk);
		if (done !== 1'b1)
		begin
			mismatches++;
			tally_and_finish;
		end
		chk("halves", e, halves);
		repeat (8) @(posedge clk);
		rd(MCG_ADDR_STATE, 8'h00, "idle");
		$display("test xfer %h %h done", c, d);
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		rd(MCG_ADDR_RATE, 8'h1f, "rate");
		rd(MCG_ADDR_STATE, 8'h00, "state");
		wr(MCG_ADDR_RATE, 8'hff);
		rd(MCG_ADDR_RATE, 8'h1f, "rate");
		wr(MCG_ADDR_RATE, 8'h02);
		wr(MCG_ADDR_CTL1, 8'h00);
		wr(MCG_ADDR_BITCNT, 8'h03);
		$display("test registers done");
		xfer(8'h81, 8'ha5);
		xfer(8'h9d, 8'h3c);
		wr(MCG_ADDR_CTL0, 8'h00);
		wr(MCG_ADDR_STATE, 8'hff);
		rd(MCG_ADDR_STATE, 8'h00, "state");
		rd(16'hff40, 8'h00, "unmapped");
		$display("test power off done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
